// ### hdl/rcs_core_ctrl.sv
// Overview of operation
// - Sleep request while running waits for the current sample or block to finish.
// - Sleeping core masks all interrupts; no samples move, processing halts.
// - Sleep register bit 0: 0 run, 1 sleep; resets 0; upper bits reserved.
// - Selected frame strobe starts each frame and sets the sample rate.
// - Codes 0-7 generators, 8-15 serial ports, 16 S/PDIF receiver.
// - Core starts only on 0-to-1 of start bit; sleep stops it.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "rcs_cfg.svh"
module rcs_core_ctrl #(
    parameter int NUM_GEN = 8,
    parameter int NUM_SER = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [17:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Frame strobe sources, asynchronous pulses of several cycles
    input wire logic [NUM_GEN-1:0] gen_strobe_in,
    input wire logic [NUM_SER-1:0] ser_frame_clk_in,
    input wire logic spdif_strobe_in,
    // Core side
    input wire logic core_busy_in,
    input wire logic [7:0] irq_in,
    output logic [7:0] irq_out,
    output logic frame_start_out,
    output logic core_start_out,
    output logic core_run_out,
    output logic core_sleep_out
);
    rcs_pkg::rcs_state_type state_reg;
    logic sleep_reg;
    logic [`RCS_SEL_W-1:0] sel_reg;
    logic start_reg;
    logic [NUM_GEN+NUM_SER:0] src_meta_reg, src_sync_reg, src_prev_reg;
    logic strobe_sync;
    logic strobe_edge;
    logic acc;
    logic wr;
    logic [15:0] idx;
    logic hit;

    // Select codes index the source vector directly, so the counts are fixed
    if (NUM_GEN != 8 || NUM_SER != 8) begin : g_bad_params
        $error("rcs_core_ctrl supports eight generator and eight serial strobes only");
    end

    function automatic logic idx_ok(input logic [15:0] i);
        idx_ok = (i == `RCS_IDX_SLEEP) || (i == `RCS_IDX_STROBE) ||
                 (i == `RCS_IDX_START) || (i == `RCS_IDX_STATUS);
    endfunction

    assign acc = psel_in && penable_in;
    assign wr = acc && pwrite_in;
    assign idx = paddr_in[17:2];
    assign hit = idx_ok(idx) && (paddr_in[1:0] == 2'b00);
    assign pready_out = 1'b1;
    assign pslverr_out = acc && !hit;

    // Control registers
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sleep_reg <= 1'b0;
            sel_reg <= 5'(`RCS_STROBE_RST);
            start_reg <= 1'b0;
        end else if (wr && hit) begin
            if (idx == `RCS_IDX_SLEEP) begin
                sleep_reg <= pwdata_in[0];
            end
            if (idx == `RCS_IDX_STROBE) begin
                sel_reg <= pwdata_in[`RCS_SEL_W-1:0];
            end
            if (idx == `RCS_IDX_START) begin
                start_reg <= pwdata_in[0];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            // Unaligned or unmapped reads return zero
            unique case (hit ? idx : 16'h0000)
                `RCS_IDX_SLEEP: prdata_out <= {31'h0, sleep_reg};
                `RCS_IDX_STROBE: prdata_out <= {27'h0, sel_reg};
                `RCS_IDX_START: prdata_out <= {31'h0, start_reg};
                `RCS_IDX_STATUS: prdata_out <= {30'h0, state_reg};
                default: prdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // Synchronise all strobe sources
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            src_meta_reg <= '0;
            src_sync_reg <= '0;
            src_prev_reg <= '0;
        end else begin
            src_meta_reg <= {spdif_strobe_in, ser_frame_clk_in, gen_strobe_in};
            src_sync_reg <= src_meta_reg;
            src_prev_reg <= src_sync_reg;
        end
    end

    always_comb begin
        if (sel_reg == `RCS_SEL_SPDIF) begin
            strobe_sync = src_sync_reg[NUM_GEN+NUM_SER] && !src_prev_reg[NUM_GEN+NUM_SER];
        end else if (sel_reg <= 5'h0f) begin
            strobe_sync = src_sync_reg[sel_reg[3:0]] && !src_prev_reg[sel_reg[3:0]];
        end else begin
            strobe_sync = 1'b0;
        end
    end
    assign strobe_edge = strobe_sync;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frame_start_out <= 1'b0;
        end else begin
            frame_start_out <= strobe_edge && (state_reg == rcs_pkg::RCS_RUN);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            core_start_out <= 1'b0;
        end else begin
            core_start_out <= wr && hit && (idx == `RCS_IDX_START) && pwdata_in[0] && !start_reg;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= rcs_pkg::RCS_IDLE;
        end else begin
            unique case (state_reg)
                rcs_pkg::RCS_IDLE: begin
                    if (core_start_out) begin
                        state_reg <= rcs_pkg::RCS_RUN;
                    end
                end
                rcs_pkg::RCS_RUN: begin
                    if (sleep_reg) begin
                        state_reg <= core_busy_in ? rcs_pkg::RCS_DRAIN : rcs_pkg::RCS_SLEEP;
                    end
                end
                rcs_pkg::RCS_DRAIN: begin
                    if (!core_busy_in) begin
                        state_reg <= rcs_pkg::RCS_SLEEP;
                    end
                end
                rcs_pkg::RCS_SLEEP: begin
                    if (!sleep_reg) begin
                        state_reg <= rcs_pkg::RCS_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_out <= 8'h00;
        end else begin
            irq_out <= sleep_reg ? 8'h00 : irq_in;
        end
    end

    assign core_run_out = (state_reg == rcs_pkg::RCS_RUN) || (state_reg == rcs_pkg::RCS_DRAIN);
    assign core_sleep_out = (state_reg == rcs_pkg::RCS_SLEEP);

    property p_irq_masked;
        @(posedge clk_in) disable iff (!rstn_in) sleep_reg |=> (irq_out == 8'h00);
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt passed while asleep");

    property p_drain;
        @(posedge clk_in) disable iff (!rstn_in)
            (state_reg == rcs_pkg::RCS_RUN && sleep_reg && core_busy_in) |=> (state_reg == rcs_pkg::RCS_DRAIN);
    endproperty
    a_drain: assert property (p_drain) else $error("sleep entered while busy");

    sequence s_drain_done;
        (state_reg == rcs_pkg::RCS_DRAIN) && !core_busy_in;
    endsequence

    sequence s_asleep;
        state_reg == rcs_pkg::RCS_SLEEP;
    endsequence

    property p_drain_done;
        @(posedge clk_in) disable iff (!rstn_in) s_drain_done |=> s_asleep;
    endproperty
    a_drain_done: assert property (p_drain_done) else $error("no sleep after drain");

    property p_no_frame_asleep;
        @(posedge clk_in) disable iff (!rstn_in) core_sleep_out |=> !frame_start_out;
    endproperty
    a_no_frame_asleep: assert property (p_no_frame_asleep) else $error("frame while asleep");

    property p_wake;
        @(posedge clk_in) disable iff (!rstn_in) (core_sleep_out && !sleep_reg) |=> core_run_out;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake after clear");

    property p_start_once;
        @(posedge clk_in) disable iff (!rstn_in) core_start_out |-> $rose(start_reg);
    endproperty
    a_start_once: assert property (p_start_once) else $error("start without rising edge");

    property p_sel_range;
        @(posedge clk_in) disable iff (!rstn_in) (sel_reg > 5'h10) |=> !frame_start_out;
    endproperty
    a_sel_range: assert property (p_sel_range) else $error("strobe from illegal code");

    property p_sleep_rd;
        @(posedge clk_in) disable iff (!rstn_in)
            (psel_in && !penable_in && !pwrite_in && paddr_in[17:2] == `RCS_IDX_SLEEP) |=> (prdata_out[31:1] == 31'h0);
    endproperty
    a_sleep_rd: assert property (p_sleep_rd) else $error("reserved sleep bits set");

    property p_sel_rd;
        @(posedge clk_in) disable iff (!rstn_in)
            (psel_in && !penable_in && !pwrite_in && hit && idx == `RCS_IDX_STROBE) |=> (prdata_out[4:0] == sel_reg);
    endproperty
    a_sel_rd: assert property (p_sel_rd) else $error("select readback wrong");
endmodule

// ### hdl/rcs_cfg.svh
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH
// Register indices; byte address is four times the index
`define RCS_IDX_SLEEP 16'hf400
`define RCS_IDX_STROBE 16'hf401
`define RCS_IDX_START 16'hf402
`define RCS_IDX_STATUS 16'hf404
`define RCS_SLEEP_RST 16'h0000
`define RCS_STROBE_RST 16'h0002
`define RCS_START_RST 16'h0000
`define RCS_SEL_W 5
`define RCS_SEL_SERIAL 5'h08
`define RCS_SEL_SPDIF 5'h10
`endif

// ### hdl/rcs_pkg.sv
package rcs_pkg;
    typedef enum logic [1:0] {
        RCS_IDLE = 2'b00,
        RCS_RUN = 2'b01,
        RCS_DRAIN = 2'b10,
        RCS_SLEEP = 2'b11
    } rcs_state_type;
endpackage

// ### tb/rcs_core_ctrl_test.sv
`timescale 1ns/1ns
`include "rcs_cfg.svh"
module rcs_core_ctrl_test;
    localparam logic [17:0] A_SLEEP = {`RCS_IDX_SLEEP, 2'b00};
    localparam logic [17:0] A_STROBE = {`RCS_IDX_STROBE, 2'b00};
    localparam logic [17:0] A_START = {`RCS_IDX_START, 2'b00};
    localparam logic [17:0] A_STATUS = {`RCS_IDX_STATUS, 2'b00};
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [17:0] paddr_in = 18'h00000;
    logic [31:0] pwdata_in = 32'h00000000;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out;
    logic [7:0] gen_strobe_in = 8'h00;
    logic [7:0] ser_frame_clk_in = 8'h00;
    logic spdif_strobe_in = 1'b0;
    logic core_busy_in = 1'b0;
    logic [7:0] irq_in = 8'h00;
    logic [7:0] irq_out;
    logic frame_start_out, core_start_out, core_run_out, core_sleep_out;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int checked = 0;
    int frames = 0;
    int starts = 0;
    rcs_core_ctrl u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .gen_strobe_in(gen_strobe_in),
        .ser_frame_clk_in(ser_frame_clk_in), .spdif_strobe_in(spdif_strobe_in), .core_busy_in(core_busy_in),
        .irq_in(irq_in), .irq_out(irq_out), .frame_start_out(frame_start_out), .core_start_out(core_start_out),
        .core_run_out(core_run_out), .core_sleep_out(core_sleep_out));
    always #2 clk_in = ~clk_in;
    // Count one-cycle pulses from the core side
    always @(posedge clk_in) begin
        if (frame_start_out === 1'b1) frames <= frames + 1;
        if (core_start_out === 1'b1) starts <= starts + 1;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [17:0] addr, input logic [31:0] wd);
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1) @(posedge clk_in);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    // Pulse the source pin behind a select code and count frame starts
    task automatic pin(input int code, input int exp_n);
        int f0;
        f0 = frames;
        @(posedge clk_in);
        if (code < 8) gen_strobe_in[code] <= 1'b1;
        else if (code < 16) ser_frame_clk_in[code-8] <= 1'b1;
        else spdif_strobe_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        gen_strobe_in <= 8'h00;
        ser_frame_clk_in <= 8'h00;
        spdif_strobe_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        chk("frame_count", frames - f0, exp_n);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #40000;
        fail_count++;
        summarize();
    end
    initial begin
        int codes[5] = '{0, 7, 8, 15, 16};
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        apb(1'b0, A_SLEEP, 32'h0);
        chk("sleep_reset", rd, 32'h00000000);
        apb(1'b0, A_STROBE, 32'h0);
        chk("strobe_reset", rd, 32'h00000002);
        apb(1'b1, A_SLEEP, 32'hffffffff);
        apb(1'b0, A_SLEEP, 32'h0);
        chk("sleep_reserved", rd, 32'h00000001);
        apb(1'b1, A_SLEEP, 32'h0);
        apb(1'b1, 18'h3d020, 32'h1);
        chk("unmapped_err", err, 32'h1);
        apb(1'b0, A_STROBE + 18'h00001, 32'h0);
        chk("unaligned_rd", rd, 32'h00000000);
        chk("unaligned_err", err, 32'h1);
        $display("test registers done");
        apb(1'b1, A_START, 32'h1);
        repeat (3) @(posedge clk_in);
        chk("start_pulses", starts, 32'h1);
        chk("run_level", core_run_out, 32'h1);
        apb(1'b1, A_START, 32'h1);
        apb(1'b1, A_START, 32'h0);
        repeat (3) @(posedge clk_in);
        chk("start_no_repulse", starts, 32'h1);
        apb(1'b1, A_START, 32'h1);
        repeat (3) @(posedge clk_in);
        chk("start_second", starts, 32'h2);
        $display("test start done");
        pin(2, 1);
        pin(3, 0);
        foreach (codes[i]) begin
            apb(1'b1, A_STROBE, 32'(codes[i]));
            pin(codes[i], 1);
            pin((codes[i] + 1) % 17, 0);
        end
        $display("test strobe select done");
        irq_in <= 8'ha5;
        core_busy_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk("irq_pass", irq_out, 32'ha5);
        apb(1'b1, A_SLEEP, 32'h1);
        apb(1'b0, A_STATUS, 32'h0);
        chk("status_drain", rd, 32'h2);
        chk("irq_masked", irq_out, 32'h0);
        core_busy_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk("sleep_level", core_sleep_out, 32'h1);
        pin(16, 0);
        apb(1'b1, A_SLEEP, 32'h0);
        repeat (2) @(posedge clk_in);
        chk("run_again", core_run_out, 32'h1);
        chk("irq_resume", irq_out, 32'ha5);
        pin(16, 1);
        apb(1'b1, A_SLEEP, 32'h1);
        repeat (2) @(posedge clk_in);
        chk("sleep_idle_core", core_sleep_out, 32'h1);
        chk("irq_masked_again", irq_out, 32'h0);
        $display("test sleep done");
        summarize();
    end
endmodule
